//--- src/cca_pkg.sv
`default_nettype none
package cca_pkg;
    typedef enum logic [2:0] {
        CCA_MODE_OFF      = 3'b000,
        CCA_MODE_CAP_POS  = 3'b001,
        CCA_MODE_CAP_NEG  = 3'b010,
        CCA_MODE_CAP_BOTH = 3'b011,
        CCA_MODE_TIMER    = 3'b100,
        CCA_MODE_HSO      = 3'b101,
        CCA_MODE_PWM8     = 3'b110,
        CCA_MODE_PWM16    = 3'b111
    } cca_mode_e;

    typedef enum logic [1:0] {
        CCA_CLK_OSC     = 2'b00,
        CCA_CLK_OSC_DIV4  = 2'b01,
        CCA_CLK_OSC_DIV12 = 2'b10,
        CCA_CLK_EXT     = 2'b11
    } cca_clk_e;

    localparam int          CCA_CHANNELS       = 4;
    localparam logic [7:0]  CCA_ADDR_CONTROL1  = 8'hA1;
    localparam logic [7:0]  CCA_ADDR_CONTROL2  = 8'hA2;
    localparam logic [7:0]  CCA_ADDR_COUNT_HI  = 8'h9A;
    localparam logic [7:0]  CCA_ADDR_COUNT_LO  = 8'h9B;
    localparam logic [7:0]  CCA_ADDR_CTRL [CCA_CHANNELS]    = '{8'hA3, 8'hA4, 8'hA5, 8'hA6};
    localparam logic [7:0]  CCA_ADDR_DATA_HI [CCA_CHANNELS] = '{8'h9C, 8'h9E, 8'h91, 8'h93};
    localparam logic [7:0]  CCA_ADDR_DATA_LO [CCA_CHANNELS] = '{8'h9D, 8'h9F, 8'h92, 8'h94};

    // Field positions
    localparam int          CCA_BIT_RUN        = 7;
    localparam int          CCA_BIT_IDLE_GATE  = 6;
    localparam int          CCA_POS_CLK_SEL    = 6;
    localparam int          CCA_BIT_TOGGLE     = 4;
    localparam int          CCA_POS_MODE       = 0;

    // Last prescaler count for each oscillator division
    localparam logic [3:0]  CCA_PRESC_LAST_DIV1  = 4'h0;
    localparam logic [3:0]  CCA_PRESC_LAST_DIV4  = 4'h3;
    localparam logic [3:0]  CCA_PRESC_LAST_DIV12 = 4'hB;

    localparam logic [7:0]  CCA_RESET_BYTE     = 8'h00;
    localparam logic [15:0] CCA_COUNT_MAX      = 16'hFFFF;
endpackage
`default_nettype wire

//--- src/cca_channel.sv
`default_nettype none
module cca_channel
    import cca_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  mode_i,
    input  wire logic [15:0] data_i,
    input  wire logic [15:0] count_i,
    input  wire logic [15:0] count_next_i,
    input  wire logic        tick_i,
    input  wire logic        run_i,
    input  wire logic        pin_i,
    output logic             capture_o,
    output logic             match_o,
    output logic             pwm_level_o
);
    typedef struct packed {
        logic pin_prev;
    } cca_chan_s;

    cca_chan_s q;
    cca_chan_s next_q;
    logic      rise;
    logic      fall;

    assign rise = pin_i & ~q.pin_prev;
    assign fall = ~pin_i & q.pin_prev;

    always_comb begin
        next_q          = q;
        next_q.pin_prev = pin_i;
        capture_o       = 1'b0;
        match_o         = 1'b0;
        pwm_level_o     = 1'b0;
        unique case (cca_mode_e'(mode_i))
            CCA_MODE_OFF:      ;
            CCA_MODE_CAP_POS:  capture_o = rise;
            CCA_MODE_CAP_NEG:  capture_o = fall;
            CCA_MODE_CAP_BOTH: capture_o = rise | fall;
            CCA_MODE_TIMER:    ;
            CCA_MODE_HSO:      match_o = tick_i && (count_next_i == data_i);
            // A zero duty value keeps the pin low, as does a cleared run bit
            CCA_MODE_PWM8:     pwm_level_o = run_i && (count_i[7:0] < data_i[7:0]);
            CCA_MODE_PWM16:    pwm_level_o = run_i && (count_i < data_i);
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

//--- src/cca_top.sv
`default_nettype none
module cca_top
    import cca_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        idle_i,
    input  wire logic        external_counter_clock_pin_i,
    input  wire logic [3:0]  channel_pin_i,
    output logic      [3:0]  channel_pin_o,
    output logic      [3:0]  channel_pin_oe_n_o,
    output logic             irq_o
);
    typedef struct packed {
        logic                  counter_run;
        logic                  counter_idle_gate;
        logic [3:0]            channel_int_enable;
        logic [1:0]            clock_source_select;
        logic [3:0]            channel_int_flag;
        logic [15:0]           array_counter;
        logic [3:0]            presc;
        logic [3:0]            channel_toggle;
        logic [3:0][2:0]       mode;
        logic [3:0][15:0]      data;
        logic                  ext_meta;
        logic                  ext_sync;
        logic                  ext_prev;
        logic [3:0]            pin_meta;
        logic [3:0]            pin_sync;
        logic [7:0]            rdata;
        logic [3:0]            pin_out;
        logic [3:0]            pin_oe_n;
        logic                  irq;
    } cca_state_s;

    cca_state_s q;
    cca_state_s next_q;

    logic        count_enable;
    logic        src_tick;
    logic        tick;
    logic        rollover;
    logic [15:0] count_next;
    logic [3:0]  presc_last;
    logic [3:0]  capture;
    logic [3:0]  match;
    logic [3:0]  pwm_level;

    function automatic logic [3:0] presc_last_of(input logic [1:0] sel);
        unique case (cca_clk_e'(sel))
            CCA_CLK_OSC_DIV4:  presc_last_of = CCA_PRESC_LAST_DIV4;
            CCA_CLK_OSC_DIV12: presc_last_of = CCA_PRESC_LAST_DIV12;
            CCA_CLK_OSC,
            CCA_CLK_EXT:       presc_last_of = CCA_PRESC_LAST_DIV1;
        endcase
    endfunction

    function automatic logic [7:0] read_byte(input cca_state_s s, input logic [7:0] addr);
        read_byte = CCA_RESET_BYTE;
        if (addr == CCA_ADDR_CONTROL1) begin
            read_byte = {s.counter_run, s.counter_idle_gate, 2'b00, s.channel_int_enable};
        end
        if (addr == CCA_ADDR_CONTROL2) begin
            read_byte = {s.clock_source_select, 2'b00, s.channel_int_flag};
        end
        if (addr == CCA_ADDR_COUNT_HI) begin
            read_byte = s.array_counter[15:8];
        end
        if (addr == CCA_ADDR_COUNT_LO) begin
            read_byte = s.array_counter[7:0];
        end
        for (int i = 0; i < CCA_CHANNELS; i++) begin
            if (addr == CCA_ADDR_CTRL[i]) begin
                read_byte = {3'b000, s.channel_toggle[i], 1'b0, s.mode[i]};
            end
            if (addr == CCA_ADDR_DATA_HI[i]) begin
                read_byte = s.data[i][15:8];
            end
            if (addr == CCA_ADDR_DATA_LO[i]) begin
                read_byte = s.data[i][7:0];
            end
        end
    endfunction

    assign count_enable = q.counter_run && !(q.counter_idle_gate && idle_i);
    assign presc_last   = presc_last_of(q.clock_source_select);
    assign src_tick     = (cca_clk_e'(q.clock_source_select) == CCA_CLK_EXT) ?
                          (q.ext_sync & ~q.ext_prev) : (q.presc >= presc_last);
    assign tick         = count_enable && src_tick;
    assign count_next   = q.array_counter + 16'h0001;
    assign rollover     = tick && (q.array_counter == CCA_COUNT_MAX);

    for (genvar g = 0; g < CCA_CHANNELS; g++) begin : g_chan
        cca_channel u_chan (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .mode_i       (q.mode[g]),
            .data_i       (q.data[g]),
            .count_i      (q.array_counter),
            .count_next_i (count_next),
            .tick_i       (tick),
            .run_i        (q.counter_run),
            .pin_i        (q.pin_sync[g]),
            .capture_o    (capture[g]),
            .match_o      (match[g]),
            .pwm_level_o  (pwm_level[g])
        );
    end

    always_comb begin
        next_q          = q;
        next_q.ext_meta = external_counter_clock_pin_i;
        next_q.ext_sync = q.ext_meta;
        next_q.ext_prev = q.ext_sync;
        next_q.pin_meta = channel_pin_i;
        next_q.pin_sync = q.pin_meta;

        // Oscillator prescaler advances only while counting
        if (count_enable && (cca_clk_e'(q.clock_source_select) != CCA_CLK_EXT)) begin
            next_q.presc = (q.presc >= presc_last) ? 4'h0 : q.presc + 4'h1;
        end
        if (tick) begin
            next_q.array_counter = count_next;
        end

        if (sfr_wr_i) begin
            if (sfr_addr_i == CCA_ADDR_CONTROL1) begin
                next_q.counter_run        = sfr_wdata_i[CCA_BIT_RUN];
                next_q.counter_idle_gate  = sfr_wdata_i[CCA_BIT_IDLE_GATE];
                next_q.channel_int_enable = sfr_wdata_i[3:0];
            end
            if (sfr_addr_i == CCA_ADDR_CONTROL2) begin
                next_q.clock_source_select = sfr_wdata_i[CCA_POS_CLK_SEL +: 2];
                next_q.channel_int_flag    = sfr_wdata_i[3:0];
            end
            if (sfr_addr_i == CCA_ADDR_COUNT_HI) begin
                next_q.array_counter[15:8] = sfr_wdata_i;
            end
            if (sfr_addr_i == CCA_ADDR_COUNT_LO) begin
                next_q.array_counter[7:0] = sfr_wdata_i;
            end
            for (int i = 0; i < CCA_CHANNELS; i++) begin
                if (sfr_addr_i == CCA_ADDR_CTRL[i]) begin
                    next_q.channel_toggle[i] = sfr_wdata_i[CCA_BIT_TOGGLE];
                    next_q.mode[i]           = sfr_wdata_i[CCA_POS_MODE +: 3];
                end
                if (sfr_addr_i == CCA_ADDR_DATA_HI[i]) begin
                    next_q.data[i][15:8] = sfr_wdata_i;
                end
                if (sfr_addr_i == CCA_ADDR_DATA_LO[i]) begin
                    next_q.data[i][7:0] = sfr_wdata_i;
                end
            end
        end

        // Hardware events override a simultaneous software write
        for (int i = 0; i < CCA_CHANNELS; i++) begin
            if (capture[i]) begin
                next_q.data[i] = q.array_counter;
                next_q.channel_int_flag[i] = 1'b1;
            end
            if (rollover && (cca_mode_e'(q.mode[i]) == CCA_MODE_TIMER)) begin
                next_q.channel_int_flag[i] = 1'b1;
            end
            if (match[i]) begin
                next_q.channel_toggle[i] = ~q.channel_toggle[i];
            end
            unique case (cca_mode_e'(next_q.mode[i]))
                CCA_MODE_HSO: begin
                    next_q.pin_out[i]  = next_q.channel_toggle[i];
                    next_q.pin_oe_n[i] = 1'b0;
                end
                CCA_MODE_PWM8,
                CCA_MODE_PWM16: begin
                    next_q.pin_out[i]  = pwm_level[i];
                    next_q.pin_oe_n[i] = 1'b0;
                end
                default: begin
                    next_q.pin_out[i]  = 1'b0;
                    next_q.pin_oe_n[i] = 1'b1;
                end
            endcase
        end

        next_q.irq   = |(next_q.channel_int_flag & next_q.channel_int_enable);
        next_q.rdata = read_byte(q, sfr_addr_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q          <= '0;
            q.pin_oe_n <= 4'hF;
        end else begin
            q <= next_q;
        end
    end

    assign sfr_rdata_o        = q.rdata;
    assign channel_pin_o      = q.pin_out;
    assign channel_pin_oe_n_o = q.pin_oe_n;
    assign irq_o              = q.irq;
endmodule
`default_nettype wire

//--- testbench/cca_properties.sv
`default_nettype none
module cca_properties (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       irq_o,
    input wire logic [3:0] channel_pin_o,
    input wire logic [3:0] channel_pin_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_rdata_reset: assert property (disable iff (1'b0) rst_i |=> sfr_rdata_o == 8'h00)
        else $error("read data not cleared by reset");
    chk_pins_reset: assert property (disable iff (1'b0) rst_i |=> &channel_pin_oe_n_o && !irq_o)
        else $error("pins or irq not idle after reset");
    chk_unused_zero: assert property (sfr_addr_i == 8'hA3 |=> sfr_rdata_o[7:5] == 3'b000 && !sfr_rdata_o[3])
        else $error("unused control bits read nonzero");
    chk_ctrl_readback: assert property (sfr_wr_i && sfr_addr_i == 8'hA3 && sfr_wdata_i[2:0] != 3'b101
        ##1 sfr_addr_i == 8'hA3 && !sfr_wr_i |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & 8'h17))
        else $error("control readback wrong");
    chk_oe_drive: assert property (sfr_wr_i && sfr_addr_i == 8'hA3 && sfr_wdata_i[2] && sfr_wdata_i[1:0] != 2'b00
        ##1 !sfr_wr_i |-> ##[0:1] !channel_pin_oe_n_o[0])
        else $error("output mode did not drive pin");
    chk_oe_release: assert property (sfr_wr_i && sfr_addr_i == 8'hA3 && sfr_wdata_i[2:0] <= 3'b100
        ##1 !sfr_wr_i |=> channel_pin_oe_n_o[0])
        else $error("input mode still drives pin");
    chk_flag_sticky: assert property (sfr_addr_i == 8'hA2 && !sfr_wr_i
        ##1 sfr_rdata_o[0] && sfr_addr_i == 8'hA2 && !sfr_wr_i |=> sfr_rdata_o[0])
        else $error("flag cleared by hardware");
    chk_irq_sticky: assert property (!sfr_wr_i ##1 irq_o && !sfr_wr_i |=> irq_o)
        else $error("irq dropped without write");
    cover property (irq_o);
    cover property (!channel_pin_oe_n_o[1]);
    cover property ($rose(channel_pin_o[3]));
endmodule
bind cca_top cca_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o), .channel_pin_o(channel_pin_o),
    .channel_pin_oe_n_o(channel_pin_oe_n_o));
`default_nettype wire

//--- testbench/cca_core_model.sv
`default_nettype none
module cca_core_model (
    input  wire logic       clk_i,
    output logic      [7:0] sfr_addr_o,
    output logic            sfr_wr_o,
    output logic      [7:0] sfr_wdata_o,
    input  wire logic [7:0] sfr_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sfr_addr_o  = 8'hFF;
        sfr_wr_o    = 1'b0;
        sfr_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        sfr_addr_o  = a;
        sfr_wdata_o = d;
        sfr_wr_o    = 1'b1;
        @(negedge clk_i);
        sfr_wr_o    = 1'b0;
        sfr_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        sfr_addr_o = a;
        @(negedge clk_i);
        d = sfr_rdata_i;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        idle    = 1'b0;
    logic        ext_pin = 1'b0;
    logic [3:0]  ch_pin  = 4'h0;
    logic [7:0]  addr, wdata, rdata, rb;
    logic        wr, irq;
    logic [3:0]  pin_o, oe_n;
    logic [15:0] cnt;
    logic        cap;
    int          failures  = 0;
    int          tests_run = 0;
    int          highs;
    int          divs [3] = '{1, 4, 12};
    logic [7:0]  regs [17] = '{8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'h91, 8'h92, 8'h93, 8'h94,
                               8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA1, 8'hA2};
    cca_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .idle_i(idle), .external_counter_clock_pin_i(ext_pin), .channel_pin_i(ch_pin),
        .channel_pin_o(pin_o), .channel_pin_oe_n_o(oe_n), .irq_o(irq));
    cca_core_model u_core (.clk_i(clk_i), .sfr_addr_o(addr), .sfr_wr_o(wr), .sfr_wdata_o(wdata), .sfr_rdata_i(rdata));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        u_core.rd(a, rb);
        check({8'h00, rb}, {8'h00, exp});
    endtask
    task automatic set_count(input logic [15:0] v);
        u_core.wr(8'h9A, v[15:8]);
        u_core.wr(8'h9B, v[7:0]);
    endtask
    task automatic run_for(input logic [7:0] a1, input int k);
        u_core.wr(8'hA1, a1);
        repeat (k) @(negedge clk_i);
        u_core.wr(8'hA1, 8'h00);
        repeat (20) @(negedge clk_i);
        u_core.rd(8'h9A, cnt[15:8]);
        u_core.rd(8'h9B, cnt[7:0]);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400us;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        foreach (regs[i]) expect_reg(regs[i], 8'h00);
        for (int i = 0; i < 15; i++) u_core.wr(regs[i], 8'hFF);
        for (int i = 0; i < 15; i++) expect_reg(regs[i], i < 10 ? 8'hFF : (i < 14 ? 8'h17 : 8'h00));
        for (int i = 0; i < 15; i++) u_core.wr(regs[i], 8'h00);
        for (int s = 0; s < 3; s++) begin
            u_core.wr(8'hA2, 8'(s << 6));
            set_count(16'h0000);
            run_for(8'h80, 48);
            check(16'(cnt >= 48 / divs[s] - 1 && cnt <= 48 / divs[s] + 3), 16'h0001);
        end
        u_core.wr(8'hA2, 8'hC0);
        set_count(16'h0000);
        u_core.wr(8'hA1, 8'h80);
        repeat (6) begin
            repeat (3) @(negedge clk_i);
            ext_pin = 1'b1;
            repeat (3) @(negedge clk_i);
            ext_pin = 1'b0;
        end
        run_for(8'h80, 8);
        check(cnt, 16'h0006);
        u_core.wr(8'hA2, 8'h00);
        idle = 1'b1;
        set_count(16'h0000);
        run_for(8'hC0, 30);
        check(cnt, 16'h0000);
        run_for(8'h80, 30);
        check(16'(cnt >= 30 && cnt <= 33), 16'h0001);
        idle = 1'b0;
        u_core.wr(8'hA3, 8'h04);
        set_count(16'hFFFE);
        run_for(8'h81, 8);
        u_core.wr(8'hA1, 8'h01);
        repeat (50) @(negedge clk_i);
        check({15'h0, irq}, 16'h0001);
        expect_reg(8'hA2, 8'h01);
        expect_reg(8'hA2, 8'h01);
        u_core.wr(8'hA2, 8'h00);
        repeat (3) @(negedge clk_i);
        check({15'h0, irq}, 16'h0000);
        u_core.wr(8'hA4, 8'h05);
        u_core.wr(8'h9F, 8'h10);
        for (int t = 0; t < 2; t++) begin
            set_count(16'h0000);
            run_for(8'h80, 30);
            check({14'h0, pin_o[1], oe_n[1]}, t ? 16'h0000 : 16'h0002);
            expect_reg(8'hA4, t ? 8'h05 : 8'h15);
        end
        for (int m = 1; m < 4; m++) begin
            u_core.wr(8'hA5, 8'(m));
            for (int e = 0; e < 2; e++) begin
                u_core.wr(8'hA2, 8'h00);
                set_count({8'h5A, 8'(16 * m + e)});
                ch_pin = ch_pin ^ 4'hC;
                repeat (8) @(negedge clk_i);
                cap = e ? m[1] : m[0];
                expect_reg(8'hA2, {5'h00, cap, 2'b00});
                if (cap) expect_reg(8'h92, 8'(16 * m + e));
            end
        end
        for (int p = 0; p < 2; p++) begin
            u_core.wr(8'hA6, 8'h06 + 8'(p));
            u_core.wr(8'h94, p ? 8'h00 : 8'h80);
            u_core.wr(8'hA1, 8'h80);
            highs = 0;
            repeat (4) @(negedge clk_i);
            repeat (512) begin
                @(negedge clk_i);
                if (pin_o[3] === 1'b1) highs++;
            end
            check(16'(highs), p ? 16'h0000 : 16'h0100);
            u_core.wr(8'hA1, 8'h00);
            repeat (3) @(negedge clk_i);
            check({15'h0, pin_o[3]}, 16'h0000);
        end
        // Duty 0100h near a low byte of F0h tells 16-bit from 8-bit compare
        u_core.wr(8'hA6, 8'h07);
        u_core.wr(8'h93, 8'h01);
        set_count(16'h00F0);
        u_core.wr(8'hA1, 8'h80);
        repeat (4) @(negedge clk_i);
        check({15'h0, pin_o[3]}, 16'h0001);
        repeat (20) @(negedge clk_i);
        check({15'h0, pin_o[3]}, 16'h0000);
        // Reset again while the counter runs
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        check({11'h0, irq, oe_n}, 16'h000F);
        expect_reg(8'hA6, 8'h00);
        expect_reg(8'h93, 8'h00);
        expect_reg(8'h9B, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
